// ### verification/chan_monitor.sv
// Checker of gating and write protection at the register outputs
`timescale 1ns/1ps
module chan_monitor (
   input wire logic        clk_in, rstn_in, tx_write_out, rx_read_out,
   input wire logic [7:0]  line_format_out, modem_control_out,
   input wire logic [7:0]  enhanced_features_out, alt_function_out,
   input wire logic [7:0]  fifo_setup_out, flow_threshold_out,
   input wire logic [15:0] baud_divisor_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   sequence one_pulse;
      tx_write_out ##1 !tx_write_out;
   endsequence
   AST_LF_RESET: assert property (disable iff (1'b0)
      !rstn_in |=> line_format_out == 8'h1d) else $error("format reset");
   AST_TX_PULSE: assert property (tx_write_out |-> one_pulse)
      else $error("tx pulse");
   AST_TX_GATE: assert property (
      tx_write_out |-> !$past(line_format_out[7])) else $error("tx gate");
   AST_RX_GATE: assert property (
      rx_read_out |-> !$past(line_format_out[7])) else $error("rx gate");
   AST_DIV: assert property ($changed(baud_divisor_out)
      |-> $past(line_format_out[7])) else $error("divisor gate");
   AST_ALT: assert property ($changed(alt_function_out)
      |-> $past(line_format_out[7:5]) == 3'h4) else $error("alt gate");
   AST_EFR: assert property ($changed(enhanced_features_out)
      |-> $past(line_format_out) == 8'hbf) else $error("enh gate");
   AST_MC7: assert property ($changed(modem_control_out[7])
      |-> $past(enhanced_features_out[4])) else $error("mc7 guard");
   AST_TXTRIG: assert property ($changed(fifo_setup_out[5:4])
      |-> $past(enhanced_features_out[4])) else $error("trig guard");
   AST_TCR: assert property ($changed(flow_threshold_out)
      |-> $past(enhanced_features_out[4]) && $past(modem_control_out[6]))
      else $error("threshold gate");
endmodule : chan_monitor
bind uart_chan_select chan_monitor mon (.clk_in, .rstn_in, .tx_write_out,
   .rx_read_out, .line_format_out, .modem_control_out, .fifo_setup_out,
   .enhanced_features_out, .alt_function_out, .flow_threshold_out,
   .baud_divisor_out);

// ### verification/host_model.sv
// Host processor model on the parallel register bus
`timescale 1ns/1ps
module host_model (
   input  wire logic [7:0] rdata_in,
   input  wire logic       clk_in,
   output logic      [3:0] cs_n_out,
   output logic            rd_n_out, wr_n_out,
   output logic      [2:0] addr_out,
   output logic      [7:0] data_out
);
   initial {cs_n_out, rd_n_out, wr_n_out, addr_out, data_out} = '1;
   // Address settles 4 clocks, strobe low 8, then idle 6 for the synchroniser
   task automatic acc(input logic wr, input logic [2:0] a,
                      input logic [7:0] d, output logic [7:0] q);
      addr_out <= a;
      data_out <= d;
      cs_n_out <= 4'he;
      repeat (4) @(posedge clk_in);
      rd_n_out <= wr;
      wr_n_out <= !wr;
      repeat (8) @(posedge clk_in);
      q = rdata_in;
      {rd_n_out, wr_n_out, cs_n_out} <= '1;
      data_out <= ~d;  // Released lines do not keep the old value
      repeat (6) @(posedge clk_in);
   endtask : acc
endmodule : host_model

// ### verification/tb_top.sv
// Self-checking bench for the channel register select block
`timescale 1ns/1ps
module tb_top;
   logic        clk_in = 0, rstn_in = 0, rd_n, wr_n, txw, rxr, rfr, tfr;
   logic [3:0]  cs_n;
   logic [2:0]  addr;
   logic [7:0]  wd, rdata, q, lf, mc, fs, txh, tl;
   logic [7:0]  core = 8'h5a;  // Core status, fixed so syncing is moot
   logic [15:0] div;
   logic [15:0] ntx = '0, nrx = '0, nclr = '0;  // Pulse counts
   int          err_count = 0, checked = 0, cyc = 0;
   initial forever #50 clk_in = ~clk_in;
   // Count one-cycle pulses away from the edge that launches them
   always @(negedge clk_in) begin
      ntx  <= ntx + {15'h0000, txw};
      nrx  <= nrx + {15'h0000, rxr};
      nclr <= nclr + {15'h0000, rfr} + {15'h0000, tfr};
   end
   host_model h (.clk_in, .rdata_in(rdata), .cs_n_out(cs_n), .rd_n_out(rd_n),
      .wr_n_out(wr_n), .addr_out(addr), .data_out(wd));
   uart_chan_select dut (.clk_in, .rstn_in, .cs_n_in(cs_n), .rd_n_in(rd_n),
      .wr_n_in(wr_n), .addr_in(addr), .data_in(wd), .data_out(rdata),
      .data_oe_out(), .rx_holding_in(core), .rx_read_out(rxr),
      .tx_holding_out(txh), .tx_write_out(txw), .int_source_in(core),
      .line_state_in(~core), .modem_state_in(core ^ 8'h0f),
      .rx_ready_in(core[7:4]), .tx_ready_in(core[3:0]),
      .interrupt_enable_out(), .fifo_setup_out(fs), .rx_fifo_reset_out(rfr),
      .tx_fifo_reset_out(tfr), .line_format_out(lf), .modem_control_out(mc),
      .baud_divisor_out(div), .alt_function_out(), .enhanced_features_out(),
      .resume_char_first_out(), .resume_char_second_out(),
      .pause_char_first_out(), .pause_char_second_out(),
      .flow_threshold_out(), .fifo_trigger_levels_out(tl));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic w(input logic [2:0] a, input logic [7:0] d);
      h.acc(1'b1, a, d, q);
   endtask : w
   task automatic rc(input logic [2:0] a, input logic [7:0] e);
      h.acc(1'b0, a, 8'h00, q);
      chk(q, e);
   endtask : rc
   task automatic t_base;
      rc(3'h3, 8'h1d);
      w(3'h7, 8'ha5);
      rc(3'h7, 8'ha5);
      w(3'h1, 8'h3c);
      rc(3'h1, 8'h3c);
      rc(3'h5, ~core);
      rc(3'h6, core ^ 8'h0f);
      w(3'h0, 8'hc3);
      chk(txh, 8'hc3);
      chk(ntx, 16'h0001);
      rc(3'h0, core);
      chk(nrx, 16'h0001);
      w(3'h2, 8'h31);
      chk(fs, 8'h01);
      rc(3'h2, {2'b11, core[5:0]});
   endtask : t_base
   task automatic t_div;
      w(3'h3, 8'h80);
      w(3'h0, 8'h34);
      w(3'h1, 8'h12);
      chk(div, 16'h1234);
      chk(ntx, 16'h0001);
      w(3'h2, 8'h5b);
      rc(3'h2, 8'h5b);
      w(3'h3, 8'h03);
      rc(3'h0, core);
   endtask : t_div
   task automatic t_enh;
      w(3'h4, 8'h80);
      chk(mc, 8'h00);
      w(3'h3, 8'hbf);
      chk(lf, 8'hbf);
      w(3'h2, 8'h10);
      rc(3'h2, 8'h10);
      for (int i = 4; i < 8; i++) w(i[2:0], 8'h40 + i[7:0]);
      for (int i = 4; i < 8; i++) rc(i[2:0], 8'h40 + i[7:0]);
      w(3'h3, 8'h03);
      w(3'h4, 8'hc4);
      chk(mc, 8'hc4);
      rc(3'h7, core);
      w(3'h7, 8'h77);
      chk(tl, 8'h77);
      w(3'h4, 8'h40);
      w(3'h6, 8'h66);
      rc(3'h6, 8'h66);
      rc(3'h7, 8'h77);
      w(3'h2, 8'h37);
      chk(fs, 8'h31);
      chk(nclr, 16'h0002);
   endtask : t_enh
   task automatic close_out;
      $display("errors %0d checks %0d", err_count, checked);
      if (err_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : close_out
   // About 39 accesses of 18 clocks each; the ceiling leaves ample slack
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         close_out;
      end
   end
   initial begin
      repeat (20) @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      t_base;
      t_div;
      t_enh;
      close_out;
   end
endmodule : tb_top

// ### verilog/byte_reg.sv
// One host-writable byte with a per-bit write protect mask
`timescale 1ns/1ps
module byte_reg #(
   parameter logic [7:0] RESET = 8'h00
) (
   input  wire logic       clk_in,    // Device clock
   input  wire logic       rstn_in,   // Synchronous reset, active low
   input  wire logic       we_in,     // Write strobe, one cycle
   input  wire logic [7:0] mask_in,   // Bits allowed to change
   input  wire logic [7:0] wdata_in,  // Write data
   output logic      [7:0] q_out      // Stored byte
);

   // Protected bits keep their old value on write
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         q_out <= RESET;
      end else if (we_in) begin
         q_out <= (wdata_in & mask_in) | (q_out & ~mask_in);
      end
   end

endmodule : byte_reg

// ### verilog/pin_sync.sv
// Three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk_in,   // Device clock
   input  wire logic             rstn_in,  // Synchronous reset, active low
   input  wire logic [WIDTH-1:0] d_in,     // Asynchronous level
   output logic      [WIDTH-1:0] q_out     // Filtered level
);

   // ------------------------------------------------------------------------
   // Stages
   // ------------------------------------------------------------------------
   logic [WIDTH-1:0] meta;   // First stage, read only by the second
   logic [WIDTH-1:0] s2;     // Second stage
   logic [WIDTH-1:0] s3;     // Third stage

   // Shift chain
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         meta <= '0;
         s2   <= '0;
         s3   <= '0;
      end else begin
         meta <= d_in;
         s2   <= meta;
         s3   <= s2;
      end
   end

   // A change is taken once the two later stages agree, per bit
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         q_out <= '0;
      end else begin
         q_out <= (s2 & s3) | (q_out & (s2 | s3));
      end
   end

endmodule : pin_sync

// ### verilog/uart_chan_pkg.sv
// Types shared by the channel register select block
package uart_chan_pkg;

   // ------------------------------------------------------------------------
   // Host bus request, one per clock
   // ------------------------------------------------------------------------
   typedef struct packed {
      logic       rd;     // Read strobe, chip selected
      logic       wr;     // Write strobe, chip selected
      logic [2:0] addr;   // Register address
      logic [7:0] wdata;  // Write data
   } bus_req_t;

   // ------------------------------------------------------------------------
   // Decoded register targets
   // ------------------------------------------------------------------------
   typedef enum logic [4:0] {
      sel_none, sel_holding, sel_int_enable, sel_int_id, sel_fifo_setup,
      sel_line_format, sel_modem_control, sel_line_state, sel_modem_state,
      sel_scratch, sel_div_low, sel_div_high, sel_alt_function,
      sel_enhanced, sel_resume1, sel_resume2, sel_pause1, sel_pause2,
      sel_threshold, sel_trigger, sel_ready_sum
   } reg_sel_t;

   // ------------------------------------------------------------------------
   // Bus access phase (Gray coded along idle -> active -> done)
   // ------------------------------------------------------------------------
   typedef enum logic [1:0] {
      ph_idle   = 2'b00,
      ph_active = 2'b01,
      ph_done   = 2'b11
   } bus_phase_t;

endpackage : uart_chan_pkg

// ### verilog/uart_chan_regs.svh
// Register offsets, field positions and reset values for one serial channel
`ifndef UART_CHAN_REGS_SVH
`define UART_CHAN_REGS_SVH

// ---------------------------------------------------------------------------
// Register offsets (three address lines)
// ---------------------------------------------------------------------------
`define ADDR_HOLDING      3'h0
`define ADDR_INT_ENABLE   3'h1
`define ADDR_INT_FIFO     3'h2
`define ADDR_LINE_FORMAT  3'h3
`define ADDR_MODEM_CTRL   3'h4
`define ADDR_LINE_STATE   3'h5
`define ADDR_MODEM_STATE  3'h6
`define ADDR_SCRATCH      3'h7

// ---------------------------------------------------------------------------
// Gating values and field positions
// ---------------------------------------------------------------------------
`define LF_ENHANCED_KEY   8'hbf
`define LF_ALT_KEY        3'h4
`define LF_GATE_BIT       7
`define EF_ENHANCED_BIT   4
`define MC_CLOCK_SEL_BIT  7
`define MC_THRESH_EN_BIT  6
`define MC_LOOPBACK_BIT   4
`define MC_READY_EN_BIT   2
`define FS_TX_TRIG_HI     5
`define FS_TX_TRIG_LO     4
`define FS_RX_RESET_BIT   1
`define FS_TX_RESET_BIT   2

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define RST_LINE_FORMAT   8'h1d
`define RST_BYTE          8'h00

`endif

// ### verilog/uart_chan_select.sv
// Register select and register layout for one serial channel
//
// Behaviour
// - Target chosen by address plus gating bits
// - Address 0 reads rx, writes tx holding
// - Address 1 is interrupt enable byte
// - Address 2 read gives interrupt identification
// - Address 2 write is fifo setup byte
// - Line format at 3 always reachable
// - Modem control at 4 outside enhanced state
// - Address 5 reads line state byte
// - Address 6 reads modem state byte
// - Address 7 is scratch byte normally
// - Gate bit maps divisor bytes at 0,1
// - Format 100 maps alternate function at 2
// - Key 0xbf maps enhanced and flow characters
// - Enhanced feature byte bit layout
// - Threshold/trigger bytes need both enable bits
// - Ready summary at 7 when enabled
// - Modem clock select protected by enhanced bit
// - Tx trigger field protected by enhanced bit
`timescale 1ns/1ps
`include "uart_chan_regs.svh"
module uart_chan_select
   import uart_chan_pkg::*;
(
   input  wire logic       clk_in,           // Device clock, 10 MHz
   input  wire logic       rstn_in,          // Synchronous reset, active low
   input  wire logic [3:0] cs_n_in,          // Channel selects, active low
   input  wire logic       rd_n_in,          // Read strobe, active low
   input  wire logic       wr_n_in,          // Write strobe, active low
   input  wire logic [2:0] addr_in,          // Register address
   input  wire logic [7:0] data_in,          // Data from host
   output logic      [7:0] data_out,         // Data to host
   output logic            data_oe_out,      // Data pins driven
   input  wire logic [7:0] rx_holding_in,    // Receive data from core
   output logic            rx_read_out,      // Pulse: receive byte taken
   output logic      [7:0] tx_holding_out,   // Transmit data to core
   output logic            tx_write_out,     // Pulse: transmit byte loaded
   input  wire logic [7:0] int_source_in,    // Interrupt id low bits
   input  wire logic [7:0] line_state_in,    // Line state from core
   input  wire logic [7:0] modem_state_in,   // Modem state from core
   input  wire logic [3:0] rx_ready_in,      // Rx ready, channels D..A
   input  wire logic [3:0] tx_ready_in,      // Tx ready, channels D..A
   output logic      [7:0] interrupt_enable_out,  // Interrupt enable byte
   output logic      [7:0] fifo_setup_out,        // Fifo setup byte
   output logic            rx_fifo_reset_out,     // Pulse: clear rx fifo
   output logic            tx_fifo_reset_out,     // Pulse: clear tx fifo
   output logic      [7:0] line_format_out,       // Line format byte
   output logic      [7:0] modem_control_out,     // Modem control byte
   output logic     [15:0] baud_divisor_out,      // Baud divisor
   output logic      [7:0] alt_function_out,      // Alternate function
   output logic      [7:0] enhanced_features_out, // Enhanced features
   output logic      [7:0] resume_char_first_out, // First resume char
   output logic      [7:0] resume_char_second_out,// Second resume char
   output logic      [7:0] pause_char_first_out,  // First pause char
   output logic      [7:0] pause_char_second_out, // Second pause char
   output logic      [7:0] flow_threshold_out,    // Flow threshold
   output logic      [7:0] fifo_trigger_levels_out// Trigger levels
);

   // ------------------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------------------
   // Host strobes are asynchronous; strobes must last well over two clocks
   // since a change is only seen once two later stages agree.
   logic [14:0] pins_raw;     // Raw strobe, select and address pins
   logic [14:0] pins_sync;    // Filtered copy
   logic [7:0]  wdata_sync;   // Filtered write data
   logic        rd_act;       // Read strobe active, chip selected
   logic        wr_act;       // Write strobe active, chip selected
   bus_req_t    req;          // Request carried as one bundle

   assign pins_raw = {cs_n_in, rd_n_in, wr_n_in, addr_in, 6'h00};

   pin_sync #(.WIDTH(15)) u_pin_sync (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .d_in    (pins_raw),
      .q_out   (pins_sync)
   );

   pin_sync #(.WIDTH(8)) u_data_sync (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .d_in    (data_in),
      .q_out   (wdata_sync)
   );

   // Pins reset to zero, so strobes idle low until released: needs enable
   // by chip select too, which also reads as active low right after reset.
   logic boot_done;           // Set once the synchroniser has settled
   logic [2:0] boot_cnt;      // Settling counter

   // Hold off decoding until the chains carry real pin levels
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         boot_cnt  <= 3'h0;
         boot_done <= 1'b0;
      end else if (!boot_done) begin
         boot_cnt  <= boot_cnt + 3'h1;
         boot_done <= (boot_cnt == 3'h4);
      end
   end

   assign rd_act = boot_done & (pins_sync[14:11] != 4'hf) & !pins_sync[10];
   assign wr_act = boot_done & (pins_sync[14:11] != 4'hf) & !pins_sync[9];

   always_comb begin
      req.rd    = rd_act & !wr_act;
      req.wr    = wr_act & !rd_act;
      req.addr  = pins_sync[8:6];
      req.wdata = wdata_sync;
   end

   // ------------------------------------------------------------------------
   // Access phase: one side effect per strobe
   // ------------------------------------------------------------------------
   bus_phase_t phase;         // Current phase
   bus_phase_t next_phase;    // Next phase
   logic       start_rd;      // First cycle of a read
   logic       start_wr;      // First cycle of a write

   // Phase progression
   always_comb begin
      case (phase)
         ph_idle:   next_phase = (req.rd | req.wr) ? ph_active : ph_idle;
         ph_active: next_phase = ph_done;
         ph_done:   next_phase = (req.rd | req.wr) ? ph_done : ph_idle;
         default:   next_phase = ph_idle;
      endcase
   end

   // Phase register
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         phase <= ph_idle;
      end else begin
         phase <= next_phase;
      end
   end

   assign start_rd = (phase == ph_idle) & req.rd;
   assign start_wr = (phase == ph_idle) & req.wr;

   // ------------------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------------------
   logic     gate_div;        // Divisor gate set
   logic     gate_alt;        // Alternate function gate
   logic     gate_enh;        // Enhanced access key loaded
   logic     gate_thr;        // Threshold and trigger enabled
   logic     sum_en;          // Ready summary enabled
   reg_sel_t rsel;            // Read target
   reg_sel_t wsel;            // Write target
   logic     cs_sel_any;      // Any channel select low

   assign cs_sel_any = (pins_sync[14:11] != 4'hf);
   assign gate_div = line_format_out[`LF_GATE_BIT];
   assign gate_alt = (line_format_out[7:5] == `LF_ALT_KEY);
   assign gate_enh = (line_format_out == `LF_ENHANCED_KEY);
   assign gate_thr = enhanced_features_out[`EF_ENHANCED_BIT] &
                     modem_control_out[`MC_THRESH_EN_BIT];
   assign sum_en   = (cs_sel_any) & modem_control_out[`MC_READY_EN_BIT] &
                     !modem_control_out[`MC_LOOPBACK_BIT];

   // Read target: address and gating bits together
   always_comb begin
      case (req.addr)
         `ADDR_HOLDING:
            rsel = gate_div ? sel_div_low : sel_holding;
         `ADDR_INT_ENABLE:
            rsel = gate_div ? sel_div_high : sel_int_enable;
         `ADDR_INT_FIFO:
            if (gate_enh)      rsel = sel_enhanced;
            else if (gate_alt) rsel = sel_alt_function;
            else if (gate_div) rsel = sel_none;
            else               rsel = sel_int_id;
         `ADDR_LINE_FORMAT:
            rsel = sel_line_format;
         `ADDR_MODEM_CTRL:
            rsel = gate_enh ? sel_resume1 : sel_modem_control;
         `ADDR_LINE_STATE:
            rsel = gate_enh ? sel_resume2 : sel_line_state;
         `ADDR_MODEM_STATE:
            if (gate_enh)      rsel = sel_pause1;
            else if (gate_thr) rsel = sel_threshold;
            else               rsel = sel_modem_state;
         default:
            if (sum_en)        rsel = sel_ready_sum;
            else if (gate_enh) rsel = sel_pause2;
            else if (gate_thr) rsel = sel_trigger;
            else               rsel = sel_scratch;
      endcase
   end

   // Write target: read-only bytes have no write target
   always_comb begin
      case (rsel)
         sel_holding:    wsel = (req.addr == `ADDR_HOLDING) ?
                                sel_holding : sel_none;
         sel_int_id:     wsel = sel_fifo_setup;
         sel_line_state: wsel = sel_none;
         sel_modem_state:wsel = sel_none;
         sel_ready_sum:  wsel = gate_enh ? sel_pause2 :
                                gate_thr ? sel_trigger : sel_scratch;
         default:        wsel = rsel;
      endcase
   end

   // ------------------------------------------------------------------------
   // Stored bytes
   // ------------------------------------------------------------------------
   logic [7:0] mc_mask;       // Modem control writable bits
   logic [7:0] fs_mask;       // Fifo setup writable bits
   logic       enh_on;        // Enhanced functions enabled

   assign enh_on  = enhanced_features_out[`EF_ENHANCED_BIT];
   // Clock select only changes with enhanced functions on
   assign mc_mask = {enh_on, 7'h7f};
   // Tx trigger field is enhanced; fifo clear bits are never stored
   assign fs_mask = {2'h3, enh_on, enh_on, 4'h9};

   byte_reg u_ier (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_int_enable)), .mask_in(8'hff),
      .wdata_in(req.wdata), .q_out(interrupt_enable_out));
   byte_reg u_fs (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_fifo_setup)), .mask_in(fs_mask),
      .wdata_in(req.wdata), .q_out(fifo_setup_out));
   byte_reg #(.RESET(`RST_LINE_FORMAT)) u_lf (.clk_in(clk_in),
      .rstn_in(rstn_in), .we_in(start_wr & (wsel == sel_line_format)),
      .mask_in(8'hff), .wdata_in(req.wdata),
      .q_out(line_format_out));
   byte_reg u_mc (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_modem_control)), .mask_in(mc_mask),
      .wdata_in(req.wdata), .q_out(modem_control_out));
   byte_reg u_dll (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_div_low)), .mask_in(8'hff),
      .wdata_in(req.wdata), .q_out(baud_divisor_out[7:0]));
   byte_reg u_dlh (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_div_high)), .mask_in(8'hff),
      .wdata_in(req.wdata), .q_out(baud_divisor_out[15:8]));
   byte_reg u_afr (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_alt_function)), .mask_in(8'hff),
      .wdata_in(req.wdata), .q_out(alt_function_out));
   byte_reg u_efr (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_enhanced)), .mask_in(8'hff),
      .wdata_in(req.wdata), .q_out(enhanced_features_out));
   byte_reg u_resume_char_first (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_resume1)), .mask_in(8'hff),
      .wdata_in(req.wdata), .q_out(resume_char_first_out));
   byte_reg u_resume_char_second (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_resume2)), .mask_in(8'hff),
      .wdata_in(req.wdata), .q_out(resume_char_second_out));
   byte_reg u_pause_char_first (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_pause1)), .mask_in(8'hff),
      .wdata_in(req.wdata), .q_out(pause_char_first_out));
   byte_reg u_pause_char_second (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_pause2)), .mask_in(8'hff),
      .wdata_in(req.wdata), .q_out(pause_char_second_out));
   byte_reg u_tcr (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_threshold)), .mask_in(8'hff),
      .wdata_in(req.wdata), .q_out(flow_threshold_out));
   byte_reg u_tlr (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_trigger)), .mask_in(8'hff),
      .wdata_in(req.wdata), .q_out(fifo_trigger_levels_out));

   logic [7:0] scratch_byte;  // General-purpose byte, no side effects
   byte_reg u_spr (.clk_in(clk_in), .rstn_in(rstn_in),
      .we_in(start_wr & (wsel == sel_scratch)), .mask_in(8'hff),
      .wdata_in(req.wdata), .q_out(scratch_byte));

   // ------------------------------------------------------------------------
   // Side-effect pulses
   // ------------------------------------------------------------------------
   // Transmit byte load and fifo clears are one-cycle strobes to the core;
   // the reset bits self-clear, so they are never stored.
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         tx_holding_out    <= `RST_BYTE;
         tx_write_out      <= 1'b0;
         rx_read_out       <= 1'b0;
         rx_fifo_reset_out <= 1'b0;
         tx_fifo_reset_out <= 1'b0;
      end else begin
         tx_write_out      <= start_wr & (wsel == sel_holding);
         rx_read_out       <= start_rd & (rsel == sel_holding);
         rx_fifo_reset_out <= start_wr & (wsel == sel_fifo_setup) &
                              req.wdata[`FS_RX_RESET_BIT];
         tx_fifo_reset_out <= start_wr & (wsel == sel_fifo_setup) &
                              req.wdata[`FS_TX_RESET_BIT];
         if (start_wr & (wsel == sel_holding)) begin
            tx_holding_out <= req.wdata;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------------
   logic [7:0] next_rdata;    // Selected read byte

   // Read multiplexer
   always_comb begin
      case (rsel)
         sel_holding:       next_rdata = rx_holding_in;
         sel_int_enable:    next_rdata = interrupt_enable_out;
         // Top bits mirror the fifo enable
         sel_int_id:        next_rdata = {{2{fifo_setup_out[0]}},
                                          int_source_in[5:0]};
         sel_line_format:   next_rdata = line_format_out;
         sel_modem_control: next_rdata = modem_control_out;
         sel_line_state:    next_rdata = line_state_in;
         sel_modem_state:   next_rdata = modem_state_in;
         sel_scratch:       next_rdata = scratch_byte;
         sel_div_low:       next_rdata = baud_divisor_out[7:0];
         sel_div_high:      next_rdata = baud_divisor_out[15:8];
         sel_alt_function:  next_rdata = alt_function_out;
         sel_enhanced:      next_rdata = enhanced_features_out;
         sel_resume1:       next_rdata = resume_char_first_out;
         sel_resume2:       next_rdata = resume_char_second_out;
         sel_pause1:        next_rdata = pause_char_first_out;
         sel_pause2:        next_rdata = pause_char_second_out;
         sel_threshold:     next_rdata = flow_threshold_out;
         sel_trigger:       next_rdata = fifo_trigger_levels_out;
         sel_ready_sum:     next_rdata = {rx_ready_in, tx_ready_in};
         default:           next_rdata = `RST_BYTE;
      endcase
   end

   // Data is latched at strobe start and held for the whole strobe
   always_ff @(posedge clk_in) begin
      if (!rstn_in) begin
         data_out    <= `RST_BYTE;
         data_oe_out <= 1'b0;
      end else begin
         if (start_rd) begin
            data_out <= next_rdata;
         end
         data_oe_out <= req.rd & (start_rd | data_oe_out);
      end
   end

endmodule : uart_chan_select
